// File: core/arin_top.sv
// alarm reset input: usage setting, edge reset, fault clear and enable
`timescale 1ns/1ps
`default_nettype none
`include "arin_regs.svh"
module arin_top (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [1:0]       variant,
   input  wire arin_pkg::arin_cfg_t cfg_in,
   input  wire logic [7:0]       control_scheme,
   input  wire logic             release_sel_wr,
   input  wire logic [1:0]       release_sel,
   input  wire logic             fourth_digital_input,
   input  wire logic [4:0]       io_pins_in,
   input  wire logic [4:0]       io_direction_setup,
   input  wire logic             fault_set,
   input  wire logic [15:0]      fault_bits,
   output logic                  cfg_reject,
   output arin_pkg::arin_set_t   setting,
   output logic                  drive_fault,
   output logic [15:0]           fault_code_word,
   output logic                  alarm_reset_pulse,
   output logic                  drive_enable,
   output logic                  gp_input
);
   import arin_pkg::*;

   arin_use_t   use_reg, use_next;
   logic [2:0]  point_reg, point_next;
   logic        hw_en_reg, hw_en_next;
   logic        rej_reg, rej_next;
   logic        fault_reg, fault_next;
   logic [15:0] code_reg, code_next;
   logic        pulse_reg, pulse_next;
   logic        armed_reg, armed_next;
   logic        wait_en_reg, wait_en_next;
   logic        en_reg, en_next;
   logic        gp_reg, gp_next;
   logic        raw_sel, lvl, rise, fall;
   logic        scheme_owns, edge_hit, normal_lvl, active_lvl, point_ok;

   // input line selection; point must be both valid and set as input
   always_comb begin
      raw_sel = fourth_digital_input;
      if (variant == `ARIN_VAR_FLEX) begin
         raw_sel = io_pins_in[point_reg];
         if (!io_direction_setup[point_reg]) raw_sel = 1'b1;
      end
   end

   arin_edge u_edge (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .din     (raw_sel),
      .level   (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   // scheme ownership and level meaning (high = open, low = closed)
   always_comb begin
      scheme_owns = (variant == `ARIN_VAR_RELEASE) &&
                    (control_scheme == `ARIN_SCHEME_A || control_scheme == `ARIN_SCHEME_B ||
                     control_scheme == `ARIN_SCHEME_C || control_scheme == `ARIN_SCHEME_D);
      point_ok   = (cfg_in.point == `ARIN_POINT_A) || (cfg_in.point == `ARIN_POINT_B);
      active_lvl = (use_reg == `ARIN_USE_CLOSE) ? ~lvl : lvl;
      normal_lvl = ~active_lvl;
      edge_hit   = 1'b0;
      if (use_reg == `ARIN_USE_CLOSE) edge_hit = fall;
      if (use_reg == `ARIN_USE_OPEN)  edge_hit = rise;
      if (use_reg == `ARIN_USE_GPIO || scheme_owns) edge_hit = 1'b0;
   end

   // usage setting store
   always_comb begin
      use_next   = use_reg;
      point_next = point_reg;
      hw_en_next = hw_en_reg;
      rej_next   = 1'b0;
      if (cfg_in.wr) begin
         if (cfg_in.use_code == 2'h0) begin
            rej_next = 1'b1;
         end else if (variant == `ARIN_VAR_FLEX) begin
            if (point_ok) begin
               use_next   = cfg_in.use_code;
               point_next = cfg_in.point;
            end else begin
               rej_next = 1'b1;
            end
         end else begin
            use_next = cfg_in.use_code;
         end
      end
      if (release_sel_wr) begin
         hw_en_next = (release_sel != 2'h0);
         if (release_sel == 2'h1 || release_sel == 2'h2) use_next = `ARIN_USE_GPIO;
      end
      if (variant == `ARIN_VAR_RELEASE && scheme_owns) use_next = `ARIN_USE_GPIO;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         use_reg   <= `ARIN_USE_RESET;
         point_reg <= `ARIN_POINT_RESET;
         hw_en_reg <= 1'b0;
         rej_reg   <= 1'b0;
      end else begin
         use_reg   <= use_next;
         point_reg <= point_next;
         hw_en_reg <= hw_en_next;
         rej_reg   <= rej_next;
      end
   end

   // fault latch, arming and enable; new fault wins over a reset edge
   always_comb begin
      fault_next   = fault_reg;
      code_next    = code_reg;
      pulse_next   = 1'b0;
      armed_next   = armed_reg;
      wait_en_next = wait_en_reg;
      en_next      = en_reg;
      gp_next      = lvl;
      if (!fault_reg) armed_next = 1'b0;
      if (fault_reg && normal_lvl) armed_next = 1'b1;
      if (fault_reg && armed_reg && edge_hit) begin
         fault_next   = 1'b0;
         code_next    = `ARIN_FAULT_CLEAR;
         pulse_next   = 1'b1;
         armed_next   = 1'b0;
         wait_en_next = (variant != `ARIN_VAR_STD);
      end
      if (wait_en_reg && normal_lvl) begin
         wait_en_next = 1'b0;
         if (variant == `ARIN_VAR_RELEASE) en_next = 1'b1;
         if (variant == `ARIN_VAR_FLEX && !hw_en_reg) en_next = 1'b1;
      end
      if (variant == `ARIN_VAR_STD && pulse_next) en_next = 1'b1;
      if (fault_set) begin
         fault_next   = 1'b1;
         pulse_next   = 1'b0;                                  // fault wins, no pulse
         code_next    = code_reg | fault_bits;
         en_next      = 1'b0;
         armed_next   = 1'b0;
         wait_en_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fault_reg   <= 1'b0;
         code_reg    <= `ARIN_FAULT_CLEAR;
         pulse_reg   <= 1'b0;
         armed_reg   <= 1'b0;
         wait_en_reg <= 1'b0;
         en_reg      <= 1'b1;
         gp_reg      <= 1'b1;
      end else begin
         fault_reg   <= fault_next;
         code_reg    <= code_next;
         pulse_reg   <= pulse_next;
         armed_reg   <= armed_next;
         wait_en_reg <= wait_en_next;
         en_reg      <= en_next;
         gp_reg      <= gp_next;
      end
   end

   // outputs straight from flops
   assign cfg_reject        = rej_reg;
   assign setting.use_code  = use_reg;
   assign setting.point     = point_reg;
   assign drive_fault       = fault_reg;
   assign fault_code_word   = code_reg;
   assign alarm_reset_pulse = pulse_reg;
   assign drive_enable      = en_reg;
   assign gp_input          = gp_reg;
endmodule
`default_nettype wire

// File: core/arin_regs.svh
// constants for the alarm reset input block
// How it works
// - code 1: open is normal, reset on edge to closed (low)
// - code 2: closed is normal, reset on edge to open (high)
// - reset is edge-triggered; input already active gives no reset
// - code 3: input ignored for reset, left as general purpose input
// - valid reset event clears drive fault and fault code word
// - release-input variant: setting has no effect in schemes 13, 14, 17, 18
// - usage forced to 3 by schemes 13/14/17/18 (release-input variant only) or later release selection 1/2
// - release-input variant: drive enabled when input returns to normal after clear
// - configurable variant: second parameter picks point 2 or 4 only
// - configurable variant: enable on return to normal unless hardware enable set
// - point parameter only on configurable variant; query returns stored setting
// - energized input is low (closed), de-energized or open is high
`ifndef ARIN_REGS_SVH
`define ARIN_REGS_SVH
`define ARIN_USE_CLOSE     2'h1
`define ARIN_USE_OPEN      2'h2
`define ARIN_USE_GPIO      2'h3
`define ARIN_USE_RESET     2'h3
`define ARIN_POINT_A       3'h2
`define ARIN_POINT_B       3'h4
`define ARIN_POINT_RESET   3'h4
`define ARIN_SCHEME_A      8'h0d
`define ARIN_SCHEME_B      8'h0e
`define ARIN_SCHEME_C      8'h11
`define ARIN_SCHEME_D      8'h12
`define ARIN_FAULT_CLEAR   16'h0000
`define ARIN_VAR_STD       2'h0
`define ARIN_VAR_RELEASE   2'h1
`define ARIN_VAR_FLEX      2'h2
`endif

// File: core/arin_pkg.sv
// types for the alarm reset input block
package arin_pkg;
   typedef logic [1:0] arin_use_t;
   typedef struct packed {
      logic       wr;       // write strobe
      logic [1:0] use_code;
      logic [2:0] point;
   } arin_cfg_t;
   typedef struct packed {
      logic [1:0] use_code;
      logic [2:0] point;
   } arin_set_t;
endpackage

// File: core/arin_edge.sv
// synchroniser and edge detector for the selected input line
`timescale 1ns/1ps
`default_nettype none
module arin_edge (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next;

   // two flops then one history flop; unconnected line idles high
   always_comb begin
      s1_next = din;
      s2_next = s1_reg;
      s3_next = s2_reg;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
      end
   end

   // edges on synchronised value only
   assign level = s2_reg;
   assign rise  = s2_reg & ~s3_reg;
   assign fall  = ~s2_reg & s3_reg;
endmodule
`default_nettype wire

// File: tb/arin_switch.sv
// far side model: switch or host output driving the reset line
`timescale 1ns/1ps
`default_nettype none
module arin_switch (
   input  wire logic ref_clk,
   input  wire logic close_req,
   output logic      line
);
   // closed contact energizes the input and reads low, open reads high
   always_ff @(posedge ref_clk) line <= !close_req;
endmodule
`default_nettype wire

// File: tb/arin_props.sv
// assertions on the ports of the alarm reset input block
`timescale 1ns/1ps
`default_nettype none
module arin_props
   import arin_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [1:0]  variant,
   input wire arin_cfg_t   cfg_in,
   input wire logic [7:0]  control_scheme,
   input wire logic        release_sel_wr,
   input wire logic [1:0]  release_sel,
   input wire logic        fourth_digital_input,
   input wire logic [4:0]  io_pins_in,
   input wire logic [4:0]  io_direction_setup,
   input wire logic        fault_set,
   input wire logic [15:0] fault_bits,
   input wire logic        cfg_reject,
   input wire arin_set_t   setting,
   input wire logic        drive_fault,
   input wire logic [15:0] fault_code_word,
   input wire logic        alarm_reset_pulse,
   input wire logic        drive_enable,
   input wire logic        gp_input
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // reset pulse, usage, point, reject and enable checks
   a_pulse_one_cycle: assert property (alarm_reset_pulse |=> !alarm_reset_pulse)
      else $error("reset pulse too long");
   a_needs_fault: assert property (alarm_reset_pulse |-> $past(drive_fault))
      else $error("reset pulse without fault");
   a_clear_fault: assert property (alarm_reset_pulse |-> !drive_fault && fault_code_word == 16'h0000)
      else $error("fault not cleared");
   a_gpio_ignored: assert property (alarm_reset_pulse |-> $past(setting.use_code) != 2'h3)
      else $error("reset in general purpose use");
   a_scheme_block: assert property (alarm_reset_pulse && variant == 2'h1 |-> !($past(control_scheme) inside {8'h0d, 8'h0e, 8'h11, 8'h12}))
      else $error("reset in speed change scheme");
   a_scheme_force: assert property ((variant == 2'h1 && control_scheme inside {8'h0d, 8'h0e, 8'h11, 8'h12})[*2] |-> setting.use_code == 2'h3)
      else $error("usage not forced");
   a_point_legal: assert property (setting.point inside {3'h2, 3'h4})
      else $error("illegal point stored");
   a_reject_cause: assert property (cfg_reject |-> $past(cfg_in.wr))
      else $error("reject without write");
   a_fault_disable: assert property (drive_fault |-> !drive_enable)
      else $error("enabled during fault");
   // main scenarios
   c_pulse: cover property (alarm_reset_pulse);
   c_reject: cover property (cfg_reject);
   c_reenable: cover property (!drive_enable ##1 drive_enable);
endmodule
bind arin_top arin_props u_props (.*);
`default_nettype wire

// File: tb/test_arin_top.sv
// self-checking bench for the alarm reset input block
`timescale 1ns/1ps
`default_nettype none
module test_arin_top;
   import arin_pkg::*;
   logic ref_clk = 0, rst_n = 0, fault_set = 0, rel_wr = 0, close_req = 0, line, rej, flt, pul, en, gp;
   logic rj;
   logic [4:0] dir = 5'h00;
   logic [1:0] variant = 0, rel_sel = 0;
   logic [7:0] scheme = 0;
   logic [15:0] bits = 0, fcw, r;
   arin_cfg_t cfg = '0;
   arin_set_t set;
   int err_total = 0, n_checks = 0;
   initial forever #12.5 ref_clk = !ref_clk;
   arin_switch u_sw (.ref_clk, .close_req, .line);
   arin_top u_dut (.ref_clk, .rst_n, .variant, .cfg_in(cfg), .control_scheme(scheme),
      .release_sel_wr(rel_wr), .release_sel(rel_sel), .fourth_digital_input(line),
      .io_pins_in({5{line}}), .io_direction_setup(dir), .fault_set, .fault_bits(bits),
      .cfg_reject(rej), .setting(set), .drive_fault(flt), .fault_code_word(fcw),
      .alarm_reset_pulse(pul), .drive_enable(en), .gp_input(gp));
   // closed contact is the normal level only for usage code 2
   function automatic logic norm(input int u);
      return u == 2;
   endfunction
   task automatic chk(input logic [15:0] s, e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic report_and_stop;
      if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [1:0] u, input logic [2:0] p);
      @(posedge ref_clk) cfg <= '{1'b1, u, p};
      @(posedge ref_clk) cfg.wr <= 1'b0;
      #1 rj = rej;
      cyc(2);
   endtask
   task automatic sw(input logic c);
      @(posedge ref_clk) close_req <= c;
   endtask
   task automatic raise;
      r = 16'($urandom) | 16'h0001;
      @(posedge ref_clk) fault_set <= 1'b1;
      bits <= r;
      @(posedge ref_clk) fault_set <= 1'b0;
      cyc(2);
      chk(fcw, r);
   endtask
   // bounded look for a reset pulse
   task automatic seek(input logic want);
      logic hit;
      hit = 1'b0;
      repeat (12) begin
         @(posedge ref_clk);
         #1 hit = hit | (pul === 1'b1);
      end
      chk(hit, want);
   endtask
   initial begin
      cyc(20000);
      err_total++;
      report_and_stop;
   end
   initial begin
      void'($urandom(52));
      cyc(12);
      rst_n <= 1'b1;
      cyc(2);
      chk(set, {2'h3, 3'h4});
      chk({flt, en, gp}, 3'b011);
      for (int u = 1; u <= 3; u++) begin
         wr(u[1:0], 3'h4);
         sw(!norm(u));
         cyc(4);
         chk(gp, norm(u));
         raise();
         seek(1'b0);
         sw(norm(u));
         seek(1'b0);
         sw(!norm(u));
         seek(u != 3);
         chk(fcw, (u == 3) ? r : 16'h0000);
         chk(flt, u == 3);
         chk(en, u != 3);
      end
      @(posedge ref_clk) variant <= 2'h1;
      wr(2'h1, 3'h4);
      sw(1'b0);
      cyc(4);
      sw(1'b1);
      seek(1'b1);
      chk(en, 1'b0);
      sw(1'b0);
      cyc(6);
      chk(en, 1'b1);
      for (int k = 0; k < 4; k++) begin
         wr(2'h1, 3'h4);
         @(posedge ref_clk) scheme <= (k < 2) ? 8'(13 + k) : 8'(15 + k);
         cyc(3);
         chk(set.use_code, 2'h3);
         @(posedge ref_clk) scheme <= 8'h00;
      end
      wr(2'h1, 3'h4);
      @(posedge ref_clk) rel_wr <= 1'b1;
      rel_sel <= 2'h1;
      @(posedge ref_clk) rel_wr <= 1'b0;
      cyc(2);
      chk(set.use_code, 2'h3);
      @(posedge ref_clk) variant <= 2'h2;
      dir <= 5'h14;
      wr(2'h1, 3'h5);
      chk(set, {2'h3, 3'h4});
      chk(rj, 1'b1);
      wr(2'h2, 3'h2);
      chk(set, {2'h2, 3'h2});
      chk(rj, 1'b0);
      wr(2'h0, 3'h4);
      chk({rj, set}, {1'b1, 2'h2, 3'h2});
      sw(1'b1);
      cyc(4);
      raise();
      sw(1'b0);
      seek(1'b1);
      chk(flt, 1'b0);
      sw(1'b1);
      cyc(6);
      chk(en, 1'b0);
      @(posedge ref_clk) rel_wr <= 1'b1;
      rel_sel <= 2'h0;
      @(posedge ref_clk) rel_wr <= 1'b0;
      raise();
      sw(1'b0);
      seek(1'b1);
      sw(1'b1);
      cyc(6);
      chk(en, 1'b1);
      // corner: new fault in the same cycle as the clearing edge
      raise();
      sw(1'b0);
      cyc(2);
      @(posedge ref_clk) fault_set <= 1'b1;
      @(posedge ref_clk) fault_set <= 1'b0;
      #1 chk(pul, 1'b0);
      chk(flt, 1'b1);
      // point no longer an input reads as open
      @(posedge ref_clk) dir <= 5'h10;
      sw(1'b1);
      cyc(4);
      chk(gp, 1'b1);
      report_and_stop;
   end
endmodule
`default_nettype wire
